// ===== irqpw_cfg.svh
// Constants for the interrupt prioritizer and wake-up block.
// What this block does
// R1: 32 request inputs, four-level priority each.
// R2: Each line works level-triggered or edge-triggered.
// R3: Programmed priorities choose the forwarded request.
// R4: Low latency; higher late arrival served first.
// R5: Wake-up detector ranks lines during deep sleep.
// R6: Wait-for-irq/event suspend; send-event wakes wait-for-event waiters.
// R7: Sleep-after-handler-return sleeps on thread return.
// R8: Fixed peripheral sources sit on lines 0..31; lines 5, 9 and 27..30 carry none.
// R9: Edge latched until serviced; level follows line.
`ifndef IRQPW_CFG_SVH
`define IRQPW_CFG_SVH

// ==========================================================
// Sizes
`define IRQPW_NUM_LINES      32
`define IRQPW_PRIO_W         2
`define IRQPW_SYNC_STAGES    2

// ==========================================================
// Line numbers of the peripheral sources (R8).
`define IRQPW_LINE_GPIO      0
`define IRQPW_LINE_CMP0      1
`define IRQPW_LINE_CMP1      2
`define IRQPW_LINE_RADIO     3
`define IRQPW_LINE_RTC_CAP   4
`define IRQPW_LINE_RTC_TMO   6
`define IRQPW_LINE_CONV      7
`define IRQPW_LINE_DMA       8
`define IRQPW_LINE_SER_FIRST 10
`define IRQPW_LINE_SER_LAST  17
`define IRQPW_LINE_I2C       18
`define IRQPW_LINE_TMR_FIRST 19
`define IRQPW_LINE_WDOG      23
`define IRQPW_LINE_PWM0      24
`define IRQPW_LINE_PWM1      25
`define IRQPW_LINE_CAL       26
`define IRQPW_LINE_RADIO_EVT 31

`endif

// ===== irqpw_pkg.sv
// Types shared by the interrupt prioritizer modules.
package irqpw_pkg;
    typedef enum logic [1:0] {IRQPW_RUN, IRQPW_WAIT_IRQ, IRQPW_WAIT_EVT} irqpw_state_t;
endpackage

// ===== irqpw_rank_if.sv
// Request vector and ranking result between the top and a ranker.
`timescale 1ns/1ps
interface irqpw_rank_if #(
    parameter int N  = 32,
    parameter int PW = 2
);
    logic [N-1:0]         req;
    logic [N*PW-1:0]      prio;
    logic                 valid;
    logic [$clog2(N)-1:0] id;
    logic [PW-1:0]        win_prio;
    modport src  (output req, output prio, input valid, input id, input win_prio);
    modport rank (input req, input prio, output valid, output id, output win_prio);
endinterface

// ===== irqpw_rank.sv
// Picks the most urgent active request: lowest priority value, then lowest line.
`timescale 1ns/1ps
module irqpw_rank #(
    parameter int N  = 32,
    parameter int PW = 2
) (
    irqpw_rank_if.rank rk
);
    always_comb
    begin
        logic                 v;
        logic [$clog2(N)-1:0] id;
        logic [PW-1:0]        p;
        v  = 1'b0;
        id = '0;
        p  = '0;
        // Scanning downward with <= lets the lower line win a tie.
        for (int i = N - 1; i >= 0; i--)
        begin
            if (rk.req[i] && (!v || rk.prio[i*PW +: PW] <= p)) // R3
            begin
                v  = 1'b1;
                id = i[$clog2(N)-1:0];
                p  = rk.prio[i*PW +: PW];
            end
        end
        rk.valid    = v;
        rk.id       = id;
        rk.win_prio = p;
    end
endmodule

// ===== irqpw_top.sv
// Interrupt prioritizer, wake-up detector and core sleep control.
`timescale 1ns/1ps
`include "irqpw_cfg.svh"
module irqpw_top #(
    parameter int N  = `IRQPW_NUM_LINES,
    parameter int PW = `IRQPW_PRIO_W
) (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 reset_in,
    // Peripheral request lines, asynchronous
    input  wire logic [N-1:0]         irq_line_in,
    // Line configuration from software
    input  wire logic [N-1:0]         edge_mode_in,
    input  wire logic [N*PW-1:0]      prio_in,
    input  wire logic [N-1:0]         pend_clear_in,
    // Core handshake
    input  wire logic                 irq_ack_in,
    input  wire logic                 wait_for_irq_instr_in,
    input  wire logic                 wait_for_event_instr_in,
    input  wire logic                 send_event_instr_in,
    input  wire logic                 handler_return_in,
    input  wire logic                 sleep_after_handler_return_in,
    input  wire logic                 deep_sleep_in,
    // Forwarded request
    output logic                      irq_req_out,
    output logic [$clog2(N)-1:0]      irq_id_out,
    output logic [PW-1:0]             irq_prio_out,
    // Sleep and wake
    output logic                      core_sleep_out,
    output logic                      wake_out,
    output logic [$clog2(N)-1:0]      wake_id_out,
    output logic [N-1:0]              pending_out
);
    localparam int IW = $clog2(N);

    logic [N-1:0]               sync_a;
    logic [N-1:0]               sync_b;
    logic [N-1:0]               line_d;
    logic [N-1:0]               pending;
    logic                       event_flag;
    irqpw_pkg::irqpw_state_t    state;
    irqpw_pkg::irqpw_state_t    next_state;
    logic                       wake_now;
    logic                       evt_consume;

    irqpw_rank_if #(.N(N), .PW(PW)) ctl_if ();
    irqpw_rank_if #(.N(N), .PW(PW)) wk_if ();

    // ==========================================================
    // Input synchronisers and per-line pending state
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sync_a <= '0;
            sync_b <= '0;
            line_d <= '0;
        end
        else
        begin
            sync_a <= irq_line_in;
            sync_b <= sync_a;
            line_d <= sync_b;
        end
    end

    for (genvar i = 0; i < N; i++)
    begin : g_line
        logic rise;
        logic taken;
        assign rise  = sync_b[i] & ~line_d[i];
        assign taken = (irq_ack_in && irq_id_out == IW'(i)) || pend_clear_in[i];
        always_ff @(posedge mclk_in or posedge reset_in)
        begin
            if (reset_in)
                pending[i] <= 1'b0;
            else if (!edge_mode_in[i])
                pending[i] <= sync_b[i];                      // R2 R9
            else if (rise)
                pending[i] <= 1'b1;                           // R2 R9
            else if (taken)
                pending[i] <= 1'b0;                           // R9
        end
        AST_EDGE_LATCH: assert property (@(posedge mclk_in) disable iff (reset_in)
            edge_mode_in[i] && rise |=> pending[i]) // R9
            else $error("Edge request was not latched.");
        AST_LEVEL_FOLLOW: assert property (@(posedge mclk_in) disable iff (reset_in)
            !edge_mode_in[i] |=> pending[i] == $past(sync_b[i])) // R9
            else $error("Level request does not follow its line.");
    end

    // ==========================================================
    // Ranking: one ranker for the running controller, one for the wake-up detector
    assign ctl_if.req  = pending;
    assign ctl_if.prio = prio_in;
    // The detector only looks while the controller is powered down.
    assign wk_if.req   = deep_sleep_in ? (pending | sync_b) : '0;    // R5
    assign wk_if.prio  = prio_in;

    irqpw_rank #(.N(N), .PW(PW)) u_ctl_rank (.rk(ctl_if.rank));       // R1
    irqpw_rank #(.N(N), .PW(PW)) u_wk_rank  (.rk(wk_if.rank));        // R5

    // The winner is re-ranked every cycle, so a late higher request
    // replaces a lower one that the core has not acknowledged yet.
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            irq_req_out  <= 1'b0;
            irq_id_out   <= '0;
            irq_prio_out <= '0;
            pending_out  <= '0;
        end
        else
        begin
            irq_req_out  <= ctl_if.valid && !deep_sleep_in;          // R4
            irq_id_out   <= ctl_if.id;                               // R3 R4
            irq_prio_out <= ctl_if.win_prio;                         // R3
            pending_out  <= pending;
        end
    end

    // ==========================================================
    // Sleep control
    assign wake_now = deep_sleep_in ? wk_if.valid : ctl_if.valid;

    always_comb
    begin
        next_state  = state;
        evt_consume = 1'b0;
        case (state)
            irqpw_pkg::IRQPW_RUN:
            begin
                if (wait_for_irq_instr_in)
                    next_state = wake_now ? irqpw_pkg::IRQPW_RUN
                                          : irqpw_pkg::IRQPW_WAIT_IRQ;   // R6
                else if (wait_for_event_instr_in)
                begin
                    evt_consume = 1'b1;
                    next_state  = (event_flag || wake_now) ? irqpw_pkg::IRQPW_RUN
                                                           : irqpw_pkg::IRQPW_WAIT_EVT; // R6
                end
                else if (handler_return_in && sleep_after_handler_return_in && !wake_now)
                    next_state = irqpw_pkg::IRQPW_WAIT_IRQ;              // R7
            end
            irqpw_pkg::IRQPW_WAIT_IRQ:
                if (wake_now)
                    next_state = irqpw_pkg::IRQPW_RUN;                   // R5 R6
            irqpw_pkg::IRQPW_WAIT_EVT:
                if (wake_now || event_flag)
                begin
                    evt_consume = 1'b1;
                    next_state  = irqpw_pkg::IRQPW_RUN;                  // R6
                end
            default:
                next_state = irqpw_pkg::IRQPW_RUN;
        endcase
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state          <= irqpw_pkg::IRQPW_RUN;
            core_sleep_out <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            core_sleep_out <= next_state != irqpw_pkg::IRQPW_RUN;
        end
    end

    // A send-event in the cycle of consumption is kept: set wins.
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            event_flag <= 1'b0;
        else if (send_event_instr_in)
            event_flag <= 1'b1;                                          // R6
        else if (evt_consume)
            event_flag <= 1'b0;
    end

    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wake_out    <= 1'b0;
            wake_id_out <= '0;
        end
        else
        begin
            wake_out    <= deep_sleep_in && state != irqpw_pkg::IRQPW_RUN
                           && wk_if.valid;                               // R5
            wake_id_out <= wk_if.id;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence s_pin_rise(int k);
        edge_mode_in[k] && !irq_line_in[k] ##1 irq_line_in[k] [*3];
    endsequence

    AST_PIN_TO_PEND: assert property (s_pin_rise(0) |=> pending[0]) // R2
        else $error("Pin edge did not reach pending in time.");
    AST_REQ_PRESENT: assert property (pending != '0 && !deep_sleep_in |=> irq_req_out) // R4
        else $error("Pending request not forwarded.");
    AST_WIN_PRIO: assert property (irq_req_out && $stable(prio_in)
        |-> prio_in[irq_id_out*PW +: PW] == irq_prio_out) // R3
        else $error("Forwarded priority mismatch.");
    AST_WFI_SLEEP: assert property (state == irqpw_pkg::IRQPW_RUN && wait_for_irq_instr_in
        && !wake_now |=> core_sleep_out ##1 1'b1) // R6
        else $error("Wait-for-irq did not sleep.");
    AST_WFE_EVENT: assert property (state == irqpw_pkg::IRQPW_RUN && wait_for_event_instr_in
        && !wait_for_irq_instr_in && event_flag && !send_event_instr_in
        |=> !core_sleep_out && !event_flag) // R6
        else $error("Wait-for-event ignored a pending event.");
    AST_SLEEP_EXIT: assert property (state == irqpw_pkg::IRQPW_RUN && handler_return_in
        && sleep_after_handler_return_in && !wait_for_irq_instr_in
        && !wait_for_event_instr_in && !wake_now |=> core_sleep_out) // R7
        else $error("No sleep on handler return.");
    AST_DEEP_WAKE: assert property (state != irqpw_pkg::IRQPW_RUN && deep_sleep_in
        && wk_if.valid |=> wake_out && !core_sleep_out) // R5
        else $error("Wake-up detector did not wake the core.");
    AST_SEV_WAKES: assert property (state == irqpw_pkg::IRQPW_WAIT_EVT && send_event_instr_in
        |=> ##1 !core_sleep_out) // R6
        else $error("Send-event did not end wait-for-event.");
endmodule

// ===== irqpw_core_model.sv
// Behavioural model of the processor core that takes forwarded requests.
`timescale 1ns/1ps
module irqpw_core_model (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    // Request view and behaviour control
    input  wire logic       irq_req_in,
    input  wire logic       ack_en_in,
    input  wire logic [3:0] delay_in,
    // Acknowledge pulse
    output logic            irq_ack_out
);
    // ==========================================================
    // Acknowledge timing
    logic [3:0] wait_cnt;
    logic       taken;

    // One ack per request episode: the request lingers a cycle after the
    // ack, and taking it twice would ack whatever line ranks next.
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wait_cnt    <= 4'h0;
            taken       <= 1'b0;
            irq_ack_out <= 1'b0;
        end
        else
        begin
            irq_ack_out <= irq_req_in && ack_en_in && !taken && wait_cnt == delay_in;
            taken       <= irq_req_in && (taken || (ack_en_in && wait_cnt == delay_in));
            wait_cnt    <= irq_req_in ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ===== tb_irq_prioritizer_wake.sv
// Self-checking testbench of the interrupt prioritizer and wake-up block.
`timescale 1ns/1ps
module tb_irq_prioritizer_wake;
    // ==========================================================
    // Signals
    logic        mclk_in, reset_in, irq_ack_in, ack_en;
    logic        wait_for_irq_instr_in, wait_for_event_instr_in, send_event_instr_in;
    logic        handler_return_in, sleep_after_handler_return_in, deep_sleep_in;
    logic [31:0] irq_line_in, edge_mode_in, pend_clear_in, pending_out;
    logic [63:0] prio_in;
    logic [3:0]  ack_delay;
    logic        irq_req_out, core_sleep_out, wake_out;
    logic [4:0]  irq_id_out, wake_id_out;
    logic [1:0]  irq_prio_out;
    int          failures, tests_run, cycles;

    irqpw_top DUT (.mclk_in, .reset_in, .irq_line_in, .edge_mode_in, .prio_in,
        .pend_clear_in, .irq_ack_in, .wait_for_irq_instr_in, .wait_for_event_instr_in,
        .send_event_instr_in, .handler_return_in, .sleep_after_handler_return_in,
        .deep_sleep_in, .irq_req_out, .irq_id_out, .irq_prio_out, .core_sleep_out,
        .wake_out, .wake_id_out, .pending_out);
    irqpw_core_model core (.mclk_in, .reset_in, .irq_req_in(irq_req_out),
        .ack_en_in(ack_en), .delay_in(ack_delay), .irq_ack_out(irq_ack_in));

    initial
    begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    // ==========================================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic chk(input bit ok, input string msg);
        tests_run++;
        if (!ok)
        begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic line(input int i, input logic v, input logic e, input logic [1:0] p);
        irq_line_in[i] <= v;
        edge_mode_in[i] <= e;
        prio_in[2*i +: 2] <= p;
    endtask
    task automatic pulse_instr(input int k);
        step(1);
        if (k == 0) wait_for_irq_instr_in <= 1'b1;
        if (k == 1) wait_for_event_instr_in <= 1'b1;
        if (k == 2) send_event_instr_in <= 1'b1;
        if (k == 3) handler_return_in <= 1'b1;
        step(1);
        {wait_for_irq_instr_in, wait_for_event_instr_in} <= 2'h0;
        {send_event_instr_in, handler_return_in} <= 2'h0;
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    // ==========================================================
    // Scenarios
    task automatic t_lines;
        step(1);
        line(5, 1'b1, 1'b1, 2'h2);
        step(1);
        irq_line_in[5] <= 1'b0;
        step(3);
        #1 chk(irq_req_out === 1'b1 && irq_id_out === 5'h05, "edge request latency");
        step(4);
        #1 chk(pending_out[5] === 1'b1, "edge pending lost");
        step(1);
        pend_clear_in[5] <= 1'b1;
        step(1);
        pend_clear_in[5] <= 1'b0;
        step(2);
        #1 chk(pending_out === 32'h0 && irq_req_out === 1'b0, "edge clear");
        step(1);
        line(7, 1'b1, 1'b0, 2'h1);
        step(4);
        #1 chk(irq_id_out === 5'h07 && irq_prio_out === 2'h1, "level request");
        step(1);
        irq_line_in[7] <= 1'b0;
        step(4);
        #1 chk(pending_out === 32'h0 && irq_req_out === 1'b0, "level drop");
        step(1);
        line(12, 1'b1, 1'b1, 2'h2);
        ack_en <= 1'b1;
        ack_delay <= 4'h2;
        step(1);
        irq_line_in[12] <= 1'b0;
        step(12);
        #1 chk(pending_out === 32'h0 && irq_req_out === 1'b0, "ack clear");
        // The mode is set a cycle before the pin rises, so a held edge line
        // is seen as low, then high, by the pin-to-pending check.
        step(1);
        ack_en <= 1'b0;
        line(0, 1'b0, 1'b1, 2'h3);
        step(1);
        irq_line_in[0] <= 1'b1;
        step(5);
        #1 chk(pending_out === 32'h1, "held edge latch");
        step(1);
        pend_clear_in[0] <= 1'b1;
        step(1);
        pend_clear_in[0] <= 1'b0;
        step(3);
        #1 chk(pending_out === 32'h0 && irq_req_out === 1'b0, "edge no retrigger");
        step(1);
        irq_line_in[0] <= 1'b0;
        edge_mode_in[0] <= 1'b0;
        $display("line test done");
    endtask

    task automatic t_rank;
        for (int i = 0; i < 32; i++)
        begin
            step(1);
            ack_en <= 1'b0;
            line(i, 1'b1, 1'b0, i[1:0]);
            step(4);
            #1 chk(irq_id_out === 5'(i) && irq_prio_out === i[1:0], "line id");
            chk(pending_out === 32'h1 << i, "line position");
            step(1);
            irq_line_in[i] <= 1'b0;
            step(3);
        end
        step(1);
        line(3, 1'b1, 1'b0, 2'h3);
        line(30, 1'b1, 1'b0, 2'h1);
        step(4);
        #1 chk(irq_id_out === 5'h1E, "priority order");
        step(1);
        line(9, 1'b1, 1'b0, 2'h1);
        step(4);
        #1 chk(irq_id_out === 5'h09, "tie order");
        step(1);
        line(20, 1'b1, 1'b0, 2'h0);
        step(4);
        #1 chk(irq_id_out === 5'h14 && irq_prio_out === 2'h0, "late arrival");
        step(1);
        irq_line_in <= 32'h0;
        step(4);
        $display("rank test done");
    endtask

    task automatic t_sleep;
        pulse_instr(0);
        deep_sleep_in <= 1'b1;
        #1 chk(core_sleep_out === 1'b1, "wait for irq sleep");
        step(1);
        line(25, 1'b1, 1'b0, 2'h2);
        for (int k = 0; k < 8; k++)
        begin
            step(1);
            #1;
            if (wake_out === 1'b1) break;
        end
        chk(wake_out === 1'b1 && wake_id_out === 5'h19 && core_sleep_out === 1'b0, "wake");
        chk(irq_req_out === 1'b0, "request in deep sleep");
        step(1);
        deep_sleep_in <= 1'b0;
        pulse_instr(0);
        step(1);
        #1 chk(core_sleep_out === 1'b0, "sleep while pending");
        step(1);
        irq_line_in <= 32'h0;
        step(4);
        pulse_instr(1);
        #1 chk(core_sleep_out === 1'b1, "wait for event sleep");
        pulse_instr(2);
        step(1);
        #1 chk(core_sleep_out === 1'b0, "event wake");
        pulse_instr(2);
        pulse_instr(1);
        step(1);
        #1 chk(core_sleep_out === 1'b0, "stored event");
        pulse_instr(3);
        sleep_after_handler_return_in <= 1'b1;
        #1 chk(core_sleep_out === 1'b0, "plain return");
        pulse_instr(3);
        #1 chk(core_sleep_out === 1'b1, "sleep on return");
        step(1);
        line(19, 1'b1, 1'b0, 2'h0);
        step(6);
        #1 chk(core_sleep_out === 1'b0 && irq_id_out === 5'h13, "request wake");
        $display("sleep test done");
    endtask

    initial
    begin
        {failures, tests_run, cycles} = '0;
        {reset_in, irq_line_in, edge_mode_in, pend_clear_in, prio_in} = {1'b1, 160'h0};
        {ack_en, ack_delay, wait_for_irq_instr_in, wait_for_event_instr_in} = 7'h00;
        {send_event_instr_in, handler_return_in} = 2'h0;
        {sleep_after_handler_return_in, deep_sleep_in} = 2'h0;
        step(10);
        reset_in <= 1'b0;
        #1 chk({irq_req_out, irq_id_out, core_sleep_out, wake_out, pending_out} === 40'h0,
            "reset values");
        t_lines();
        t_rank();
        t_sleep();
        give_verdict();
    end
endmodule
